/* File: hdl/ocb_pkg.sv */
// Package: constants for the overcurrent blanking and fault latch block
package ocb_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_VDS    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CLEAR  = 8'h14;
  // CTRL field: blanking in units of 50 ns cycles, bits 7:0
  localparam int         CTRL_BLANK_W   = 8;
  localparam logic [7:0] CTRL_BLANK_RST = 8'h00;
  // VDS register fields
  localparam int         VDS_LATCH_BIT = 0;
  localparam int         VDS_THR_LSB   = 4;
  localparam int         VDS_THR_W     = 4;
  localparam logic [4:0] VDS_WIDTH     = 5'h08;
  // STATUS fields: bits 5:0 per-transistor trip, bit 8 fault
  localparam int         STAT_FAULT_BIT = 8;
  localparam int         NUM_FET        = 6;
  // Timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TRIP_MAX_NS     = 1000;
  localparam int TRIP_MAX_CYC    = TRIP_MAX_NS / CLK_PERIOD_NS;
  localparam int BLANK_500_NS    = 500;
  localparam int BLANK_500_CYC   = (BLANK_500_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ocb_pkg

/* File: hdl/ocb_blank_timer.sv */
// Retriggerable blanking timer shared by all sense channels
`timescale 1ns/1ps
module ocb_blank_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             edge_in,
  input  wire logic [CNT_W-1:0] length_in,
  output logic                  blank_out
);
  logic [CNT_W-1:0] count;

  // Counter needs at least one bit
  if (CNT_W < 1) begin : g_bad_width
    $error("CNT_W too small");
  end

  // Load on every edge, count down to zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
    end else if (edge_in) begin
      count <= length_in;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // Zero length means no blanking at all
  assign blank_out = (count != '0);
endmodule : ocb_blank_timer

/* File: hdl/ocb_overcurrent.sv */
// Overcurrent blanking, trip gating and latched drain-source fault
`timescale 1ns/1ps
// What this block does
// - Gate edges start a blanking interval
// - One blanking interval gates all channels
// - New edge restarts running blanking interval
// - Blanking defaults to zero after reset
// - Low trip input forces high-side PWM off
// - Trip to switch-off under one microsecond
// - Latched fault drives all gates low
// - Fault drives active-low indicator pin
// - Status records which transistor tripped
module ocb_overcurrent #(
  parameter int NUM_CH = 3
) (
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [7:0]        s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Controller PWM and analog front end results
  input  wire logic [NUM_CH-1:0] pwm_high_in,
  input  wire logic [NUM_CH-1:0] pwm_low_in,
  input  wire logic              comparator_trip_out_n_in,
  input  wire logic [NUM_CH-1:0] sense_amp_in,
  input  wire logic [2*NUM_CH-1:0] vds_over_in,
  // Outputs to gates and controller
  output logic [NUM_CH-1:0]      gate_high_out,
  output logic [NUM_CH-1:0]      gate_low_out,
  output logic [NUM_CH-1:0]      sense_amp_out,
  output logic                   blank_active_out,
  output logic [ocb_pkg::VDS_THR_W-1:0] drain_source_threshold_select_out,
  output logic                   fault_indicator_n_out
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Status word has room for six trip bits only
  if (NUM_CH != 3) begin : g_bad_ch
    $error("NUM_CH must be 3 to match six status bits");
  end
  // Trip path must stay well inside its time budget
  if (ocb_pkg::TRIP_MAX_CYC < 2) begin : g_bad_clk
    $error("Clock too slow for trip timing");
  end
  // The shipped blanking setting must fit its field
  if (ocb_pkg::BLANK_500_CYC >= (1 << ocb_pkg::CTRL_BLANK_W)) begin : g_bad_blank
    $error("Blanking field too narrow");
  end
  // Fault flag must sit above the trip bits
  if (ocb_pkg::STAT_FAULT_BIT < 2 * NUM_CH) begin : g_bad_stat
    $error("Fault bit overlaps trip bits");
  end
  // Latch and threshold fields share byte lane zero
  if (ocb_pkg::VDS_THR_LSB + ocb_pkg::VDS_THR_W > 8) begin : g_bad_vds
    $error("Threshold field outside byte lane zero");
  end

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [ocb_pkg::CTRL_BLANK_W-1:0] blank_len;
  logic                             drain_source_latch_mode;
  logic [ocb_pkg::VDS_THR_W-1:0]    thr_sel;
  logic [2*NUM_CH-1:0]              fet_trip;
  logic                             fault;
  logic [2*NUM_CH-1:0]              gate_prev;
  logic [2*NUM_CH-1:0]              gate_now;
  logic                             any_edge;
  logic                             blank;
  logic                             aw_hold;
  logic                             w_hold;
  logic [7:0]                       aw_addr;
  logic [31:0]                      w_data;
  logic [3:0]                       w_strb;

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  // Address and data may arrive in either order
  wire take_aw   = s_axi_awvalid_in && !aw_hold && !s_axi_bvalid_out;
  wire take_w    = s_axi_wvalid_in && !w_hold && !s_axi_bvalid_out;
  wire have_aw   = aw_hold || take_aw;
  wire have_w    = w_hold || take_w;
  wire do_write  = have_aw && have_w && !s_axi_bvalid_out;
  wire [7:0]  waddr = aw_hold ? aw_addr : s_axi_awaddr_in;
  wire [31:0] wdata = w_hold ? w_data : s_axi_wdata_in;
  wire [3:0]  wstrb = w_hold ? w_strb : s_axi_wstrb_in;
  wire wr_ctrl   = do_write && (waddr == ocb_pkg::ADDR_CTRL);
  wire wr_vds    = do_write && (waddr == ocb_pkg::ADDR_VDS);
  wire wr_clear  = do_write && (waddr == ocb_pkg::ADDR_CLEAR);
  wire wr_status = do_write && (waddr == ocb_pkg::ADDR_STATUS);
  wire wr_hit    = wr_ctrl || wr_vds || wr_clear || wr_status;
  // Clear is a one written to bit zero of the clear register
  wire clear_req = wr_clear && wstrb[0] && wdata[0];

  assign s_axi_awready_out = !aw_hold && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_hold && !s_axi_bvalid_out;

  // Hold halves until both present
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (take_aw) aw_addr <= s_axi_awaddr_in;
      if (take_w) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      aw_hold <= have_aw && !do_write;
      w_hold  <= have_w && !do_write;
    end
  end

  // ---------------------------------------------------------------
  // Write response
  // ---------------------------------------------------------------
  // Answer once both halves are in; unmapped gets an error
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= ocb_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? ocb_pkg::RESP_OKAY : ocb_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Byte lane zero carries every field
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      blank_len               <= ocb_pkg::CTRL_BLANK_RST;
      drain_source_latch_mode <= 1'b0;
      thr_sel                 <= '0;
    end else begin
      if (wr_ctrl && wstrb[0]) blank_len <= wdata[ocb_pkg::CTRL_BLANK_W-1:0];
      if (wr_vds && wstrb[0]) begin
        drain_source_latch_mode <= wdata[ocb_pkg::VDS_LATCH_BIT];
        thr_sel <= wdata[ocb_pkg::VDS_THR_LSB +: ocb_pkg::VDS_THR_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  wire take_ar = s_axi_arvalid_in && !s_axi_rvalid_out;
  // Read words assembled at the package field positions
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] vds_word;
  always_comb begin
    status_word                                          = 32'h0000_0000;
    status_word[2*NUM_CH-1:0]                            = fet_trip;
    status_word[ocb_pkg::STAT_FAULT_BIT]                 = fault;
    ctrl_word                                            = 32'h0000_0000;
    ctrl_word[ocb_pkg::CTRL_BLANK_W-1:0]                 = blank_len;
    vds_word                                             = 32'h0000_0000;
    vds_word[ocb_pkg::VDS_LATCH_BIT]                     = drain_source_latch_mode;
    vds_word[ocb_pkg::VDS_THR_LSB +: ocb_pkg::VDS_THR_W] = thr_sel;
  end
  wire rd_ctrl   = (s_axi_araddr_in == ocb_pkg::ADDR_CTRL);
  wire rd_vds    = (s_axi_araddr_in == ocb_pkg::ADDR_VDS);
  wire rd_status = (s_axi_araddr_in == ocb_pkg::ADDR_STATUS);
  wire rd_clear  = (s_axi_araddr_in == ocb_pkg::ADDR_CLEAR);
  wire rd_hit    = rd_ctrl || rd_vds || rd_status || rd_clear;
  wire [31:0] rd_mux = rd_ctrl ? ctrl_word :
                       rd_vds ? vds_word :
                       rd_status ? status_word : 32'h0000_0000;

  assign s_axi_arready_out = !s_axi_rvalid_out;

  // Read data register
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= ocb_pkg::RESP_OKAY;
    end else if (take_ar) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_mux;
      s_axi_rresp_out  <= rd_hit ? ocb_pkg::RESP_OKAY : ocb_pkg::RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Gate outputs and trip gating
  // ---------------------------------------------------------------
  // Cycle-by-cycle trip kills high side combinationally
  wire [NUM_CH-1:0] hs_gated = pwm_high_in & {NUM_CH{comparator_trip_out_n_in}};
  wire [NUM_CH-1:0] hs_next  = fault ? '0 : hs_gated;
  wire [NUM_CH-1:0] ls_next  = fault ? '0 : pwm_low_in;

  assign gate_high_out = hs_next;
  assign gate_low_out  = ls_next;
  assign gate_now      = {hs_next, ls_next};

  // ---------------------------------------------------------------
  // Blanking
  // ---------------------------------------------------------------
  // Remember gate levels to find edges
  // First edge after reset loads a zero length, so it is harmless
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_prev <= '0;
    end else begin
      gate_prev <= gate_now;
    end
  end

  // Rise or fall on any gate output
  assign any_edge = |(gate_now ^ gate_prev);

  ocb_blank_timer #(
    .CNT_W (ocb_pkg::CTRL_BLANK_W)
  ) u_blank (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .edge_in    (any_edge),
    .length_in  (blank_len),
    .blank_out  (blank)
  );

  // One blanking signal mutes every channel alike
  wire [NUM_CH-1:0] next_sense;
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_blank
      assign next_sense[ch] = blank ? 1'b0 : sense_amp_in[ch];
    end
  endgenerate

  // Registered sense outputs, quiet during reset
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sense_amp_out <= '0;
    end else begin
      sense_amp_out <= next_sense;
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  // Blanking flag and threshold select go straight out
  assign blank_active_out = blank;
  assign drain_source_threshold_select_out = thr_sel;

  // ---------------------------------------------------------------
  // Latched drain-source fault
  // ---------------------------------------------------------------
  wire [2*NUM_CH-1:0] trip_evt = drain_source_latch_mode ? vds_over_in : '0;

  // Set wins over clear, so an event in the clear cycle is kept
  wire                next_fault    = (|trip_evt) || (fault && !clear_req);
  wire [2*NUM_CH-1:0] next_fet_trip = trip_evt | (clear_req ? '0 : fet_trip);
  // Fault flag and per-transistor trip record
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault    <= 1'b0;
      fet_trip <= '0;
    end else begin
      fault    <= next_fault;
      fet_trip <= next_fet_trip;
    end
  end

  // Active-low indicator registered alongside the latch
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_indicator_n_out <= 1'b1;
    end else begin
      fault_indicator_n_out <= !next_fault;
    end
  end
endmodule : ocb_overcurrent

/* File: verif/ocb_oc_checker.sv */
// Checker: port-level assertions for the overcurrent block
`timescale 1ns/1ps
module ocb_oc_checker #(
  parameter int NUM_CH = 3
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_wvalid_in,
  input wire logic comparator_trip_out_n_in,
  input wire logic [NUM_CH-1:0] sense_amp_in,
  input wire logic [2*NUM_CH-1:0] vds_over_in,
  input wire logic [NUM_CH-1:0] gate_high_out,
  input wire logic [NUM_CH-1:0] gate_low_out,
  input wire logic [NUM_CH-1:0] sense_amp_out,
  input wire logic blank_active_out,
  input wire logic fault_indicator_n_out
);
  // Gate pattern seen by the edge detector, and any drain-source event
  wire logic [2*NUM_CH-1:0] gv = {gate_high_out, gate_low_out};
  wire logic any_vds = |vds_over_in;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  trip_gate_a: assert property (!comparator_trip_out_n_in |-> gate_high_out == '0)
    else $error("high side on during trip");
  fault_gate_a: assert property (!fault_indicator_n_out |-> gv == '0)
    else $error("gate on during fault");
  fault_cause_a: assert property ($fell(fault_indicator_n_out) |->
    $past(any_vds) || $past(any_vds, 2)) else $error("fault without event");
  fault_hold_a: assert property (!fault_indicator_n_out && !s_axi_awvalid_in
    && !s_axi_wvalid_in |=> !fault_indicator_n_out) else $error("fault dropped");
  blank_start_a: assert property ($rose(blank_active_out) |-> $past(gv) != $past(gv, 2))
    else $error("blanking without edge");
  blank_retrig_a: assert property (blank_active_out && gv != $past(gv) |=> blank_active_out)
    else $error("blanking not restarted");
  blank_mute_a: assert property (blank_active_out |=> sense_amp_out == '0)
    else $error("sense passed while blanked");
  sense_pass_a: assert property (!blank_active_out |=> sense_amp_out == $past(sense_amp_in))
    else $error("sense not passed");
  cover property ($fell(fault_indicator_n_out));
  cover property (blank_active_out && gv != $past(gv));
  cover property (!comparator_trip_out_n_in);
  cover property ($rose(fault_indicator_n_out));
endmodule : ocb_oc_checker
bind ocb_overcurrent ocb_oc_checker #(.NUM_CH(NUM_CH)) chk_u (.*);

/* File: verif/ocb_mcu_model.sv */
// Controller model: trapezoidal PWM for one commutation step
`timescale 1ns/1ps
module ocb_mcu_model (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       run_in,
  input  wire logic [2:0] step_in,
  output logic      [2:0] pwm_high_out,
  output logic      [2:0] pwm_low_out
);
  // ---------------------------------------------------------------
  // Chopper and leg selection
  // ---------------------------------------------------------------
  logic [2:0] chop;
  wire logic [1:0] hi_leg = 2'(step_in >> 1);
  wire logic [1:0] lo_leg = 2'((hi_leg + 2'h1 + step_in[0]) % 3);
  // Chop counter, frozen while stopped
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) chop <= 3'h0;
    else if (run_in) chop <= chop + 3'h1;
  end
  // Held step keeps its pattern through a stall
  assign pwm_high_out = chop[2] ? 3'h0 : 3'(1 << hi_leg);
  assign pwm_low_out  = 3'(1 << lo_leg);
endmodule : ocb_mcu_model

/* File: verif/testbench.sv */
// Testbench: register setup, blanking, trip gating and latched faults
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in, nrst_in, comparator_trip_out_n_in, run;
  logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, seed;
  logic [3:0] s_axi_wstrb_in;
  logic [2:0] sense_amp_in, step;
  logic [5:0] vds_over_in;
  wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire logic s_axi_rvalid_out, blank_active_out, fault_indicator_n_out;
  wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire logic [31:0] s_axi_rdata_out;
  wire logic [2:0] pwm_high_in, pwm_low_in, gate_high_out, gate_low_out, sense_amp_out;
  wire logic [3:0] drain_source_threshold_select_out;
  logic [33:0] exp_q[$];
  int n_mismatch, n_tests, i, j, n;
  localparam logic [1:0] OK = ocb_pkg::RESP_OKAY;
  localparam int BL = ocb_pkg::BLANK_500_CYC;
  ocb_overcurrent #(.NUM_CH(3)) dut_u (.*);
  ocb_mcu_model mcu_u (.clk_sys_in, .nrst_in, .run_in(run), .step_in(step),
    .pwm_high_out(pwm_high_in), .pwm_low_out(pwm_low_in));
  // ---------------------------------------------------------------
  // Clock, helpers and result watcher
  // ---------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Bus answers against the oldest note
  always @(negedge clk_sys_in) begin
    if (s_axi_bvalid_out && s_axi_bready_in)
      chk({s_axi_bresp_out, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid_out && s_axi_rready_in)
      chk({s_axi_rresp_out, s_axi_rdata_out}, exp_q.pop_front());
  end
  // One AXI4-Lite write (w=1) or read; e is the expected {resp, data}
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] e);
    logic ra, rw, rv;
    int k;
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_araddr_in <= a;
    s_axi_wdata_in <= d;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{w}};
    {s_axi_arvalid_in, s_axi_rready_in} <= {2{!w}};
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys_in);
      ra = w ? s_axi_awready_out : s_axi_arready_out;
      rw = s_axi_wready_out;
      rv = w ? s_axi_bvalid_out : s_axi_rvalid_out;
      @(posedge clk_sys_in);
      if (ra && w) s_axi_awvalid_in <= 1'b0;
      if (rw && w) s_axi_wvalid_in <= 1'b0;
      if (ra && !w) s_axi_arvalid_in <= 1'b0;
      if (rv) break;
    end
    s_axi_bready_in <= 1'b0;
    s_axi_rready_in <= 1'b0;
    if (k == 50) begin
      n_mismatch++;
      stop_test();
    end
  endtask : xfer
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst_in, run, step, sense_amp_in, vds_over_in, s_axi_awaddr_in, s_axi_araddr_in} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    {s_axi_rready_in, s_axi_wdata_in, n_mismatch, n_tests} = '0;
    comparator_trip_out_n_in = 1'b1;
    s_axi_wstrb_in = 4'hf;
    seed = 32'h0000_8517;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    xfer(0, ocb_pkg::ADDR_CTRL, 32'h0, {OK, 24'h0, ocb_pkg::CTRL_BLANK_RST});
    xfer(0, 8'h20, 32'h0, {ocb_pkg::RESP_SLVERR, 32'h0});
    xfer(1, 8'h20, 32'h1, {ocb_pkg::RESP_SLVERR, 32'h0});
    xfer(1, ocb_pkg::ADDR_STATUS, 32'h1ff, {OK, 32'h0});
    xfer(0, ocb_pkg::ADDR_STATUS, 32'h0, {OK, 32'h0});
    xfer(0, ocb_pkg::ADDR_CLEAR, 32'h0, {OK, 32'h0});
    // Gate edges with no blanking programmed
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      seed = xs(seed);
      sense_amp_in <= seed[2:0];
      step <= 3'(i + 1);
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk(34'({blank_active_out, sense_amp_out}), 34'({1'b0, seed[2:0]}));
    end
    xfer(1, ocb_pkg::ADDR_CTRL, 32'(BL), {OK, 32'h0});
    xfer(0, ocb_pkg::ADDR_CTRL, 32'h0, {OK, 32'(BL)});
    // One edge, then a second one while blanked
    @(posedge clk_sys_in);
    step <= 3'h5;
    n = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys_in);
      if (i == 4) step <= 3'h0;
      @(negedge clk_sys_in);
      n += blank_active_out;
    end
    chk(34'(n), 34'(5 + BL));
    // Free-running chopper on a held step
    @(posedge clk_sys_in);
    run <= 1'b1;
    repeat (24) begin
      @(posedge clk_sys_in);
      seed = xs(seed);
      sense_amp_in <= seed[2:0];
    end
    run <= 1'b0;
    @(posedge clk_sys_in);
    comparator_trip_out_n_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(34'({gate_high_out, gate_low_out}), 34'({3'h0, pwm_low_in}));
    @(posedge clk_sys_in);
    comparator_trip_out_n_in <= 1'b1;
    @(negedge clk_sys_in);
    chk(34'({gate_high_out, gate_low_out}), 34'({pwm_high_in, pwm_low_in}));
    // Events with latch mode off, then each transistor latched in turn
    for (j = 0; j < 7; j++) begin
      @(posedge clk_sys_in);
      vds_over_in <= (j == 0) ? 6'h3f : 6'(1 << (j - 1));
      @(posedge clk_sys_in);
      vds_over_in <= 6'h0;
      repeat (3) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      if (j == 0) begin
        chk(34'(fault_indicator_n_out), 34'h1);
        seed = xs(seed);
        xfer(1, ocb_pkg::ADDR_VDS, {24'h0, seed[3:0], 4'h1}, {OK, 32'h0});
        xfer(0, ocb_pkg::ADDR_VDS, 32'h0, {OK, 24'h0, seed[3:0], 4'h1});
        chk(34'(drain_source_threshold_select_out), 34'(seed[3:0]));
      end else begin
        chk(34'({fault_indicator_n_out, gate_high_out, gate_low_out}), 34'h0);
        xfer(0, ocb_pkg::ADDR_STATUS, 32'h0, {OK, 23'h0, 1'b1, 2'h0, 6'(1 << (j - 1))});
        xfer(1, ocb_pkg::ADDR_CLEAR, 32'h1, {OK, 32'h0});
        @(negedge clk_sys_in);
        chk(34'({fault_indicator_n_out, gate_low_out}), 34'({1'b1, pwm_low_in}));
      end
    end
    // Reset in mid-run returns blanking to zero
    @(posedge clk_sys_in);
    {nrst_in, sense_amp_in} <= '0; // Quiet sense input across reset
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    xfer(0, ocb_pkg::ADDR_CTRL, 32'h0, {OK, 32'h0});
    stop_test();
  end
endmodule : testbench
